// ===== hw/mer_regs.sv
// ahb-lite slave for motion and exposure test registers
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module mer_regs
   import mer_pkg::*;
#(
   // width of the exposure counter behind the two byte registers [RULE2]
   parameter int unsigned EXP_WIDTH = 16
)
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        motion_load,
   input  wire logic [7:0]  motion_horiz,
   input  wire logic [7:0]  motion_vert,
   input  wire logic [7:0]  surface_quality,
   input  wire logic        shutter_open
);
   logic [7:0]  hmot_reg;
   logic [7:0]  hmot_next;
   logic [7:0]  vmot_reg;
   logic [7:0]  vmot_next;
   logic [7:0]  surface_quality_byte_reg;
   logic [7:0]  surface_quality_byte_next;
   logic        h_read_reg;
   logic        h_read_next;
   logic [7:0]  lo_frz_reg;
   logic [7:0]  lo_frz_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [15:0] exposure_count;
   logic        rd_go;
   logic        wr_go;
   logic        ready_reg;
   logic        ready_next;
   logic        resp_reg;
   logic        resp_next;

   // registers reachable by a word read
   typedef enum logic [2:0]
   {
      MER_SEL_NONE  = 3'b000,
      MER_SEL_HMOT  = 3'b001,
      MER_SEL_VMOT  = 3'b010,
      MER_SEL_SURFACE_QUALITY_BYTE = 3'b011,
      MER_SEL_EXPHI = 3'b100,
      MER_SEL_EXPLO = 3'b101
   } mer_sel_e;

   // byte address to register; the read mux and the lo_hold_a check use it
   function automatic mer_sel_e reg_decode(input logic [11:0] addr);
      mer_sel_e sel;
      case (addr)
         MER_OFS_HMOT:   sel = MER_SEL_HMOT;
         MER_OFS_VMOT:   sel = MER_SEL_VMOT;
         MER_OFS_SURFACE_QUALITY_BYTE:  sel = MER_SEL_SURFACE_QUALITY_BYTE;
         MER_OFS_EXP_HI: sel = MER_SEL_EXPHI;
         MER_OFS_EXP_LO: sel = MER_SEL_EXPLO;
         default:        sel = MER_SEL_NONE;
      endcase
      return sel;
   endfunction

   mer_sel_e    rd_sel;
   mer_phase_e  phase_reg;
   mer_phase_e  phase_next;

   // the register pair serves exactly two bytes of exposure [RULE2]
   generate
      if (EXP_WIDTH != 16)
      begin
         $error("exposure counter width must be sixteen");
      end
   endgenerate

   mer_exp_counter #(
      .COUNT_WIDTH    (EXP_WIDTH)
   ) u_cnt (
      .clock          (clock),
      .rst_n          (rst_n),
      .shutter_open   (shutter_open),
      .exposure_count (exposure_count)
   );

   // read accepted in address phase; data registered for the data phase
   assign rd_go = hsel && hready && (htrans == MER_HTRANS_NONSEQ) && !hwrite;
   // writes are taken and dropped; every register here is read-only
   assign wr_go  = hsel && hready && (htrans == MER_HTRANS_NONSEQ) && hwrite;
   assign rd_sel = reg_decode(haddr);

   always_comb
   begin
      hmot_next   = hmot_reg;
      vmot_next   = vmot_reg;
      surface_quality_byte_next  = surface_quality_byte_reg;
      h_read_next = h_read_reg;
      lo_frz_next = lo_frz_reg;
      rdata_next  = 32'h0000_0000;
      if (motion_load)
      begin
         // signed link displacements mirrored as-is [RULE6]
         hmot_next  = motion_horiz;
         vmot_next  = motion_vert;
         surface_quality_byte_next = surface_quality;
      end
      if (rd_go)
      begin
         case (rd_sel)
            MER_SEL_HMOT:
            begin
               rdata_next  = {24'h000000, hmot_reg};
               h_read_next = 1'b1; // [RULE1]
            end
            MER_SEL_VMOT:
            begin
               // vertical reads zero unless horizontal came first [RULE1]
               rdata_next  = h_read_reg ? {24'h000000, vmot_reg} : 32'h0000_0000;
               h_read_next = 1'b0;
            end
            MER_SEL_SURFACE_QUALITY_BYTE:  rdata_next = {24'h000000, surface_quality_byte_reg};
            MER_SEL_EXPHI:
            begin
               // high byte out, low byte frozen [RULE2] [RULE5]
               rdata_next  = {24'h000000, exposure_count[15:8]};
               lo_frz_next = exposure_count[7:0];
            end
            MER_SEL_EXPLO:  rdata_next = {24'h000000, lo_frz_reg}; // [RULE5]
            default:        rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hmot_reg   <= MER_RST_HMOT;
         vmot_reg   <= MER_RST_VMOT;
         surface_quality_byte_reg  <= MER_RST_SURFACE_QUALITY_BYTE;
         h_read_reg <= 1'b0;
         lo_frz_reg <= MER_RST_EXP[7:0];
         rdata_reg  <= 32'h0000_0000;
      end
      else
      begin
         hmot_reg   <= hmot_next;
         vmot_reg   <= vmot_next;
         surface_quality_byte_reg  <= surface_quality_byte_next;
         h_read_reg <= h_read_next;
         lo_frz_reg <= lo_frz_next;
         rdata_reg  <= rdata_next;
      end
   end

   assign hrdata    = rdata_reg;
   assign hreadyout = ready_reg;
   assign hresp     = resp_reg;

   // bus side: zero wait states, always okay; read data stands one data phase
   always_comb
   begin
      phase_next = MER_ADDR;
      ready_next = 1'b1;
      resp_next  = MER_HRESP_OKAY;
      case (phase_reg)
         MER_ADDR: phase_next = rd_go ? MER_DATA : MER_ADDR;
         MER_DATA: phase_next = rd_go ? MER_DATA : MER_ADDR;
         default:  phase_next = MER_ADDR;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase_reg <= MER_ADDR;
         ready_reg <= 1'b1;
         resp_reg  <= MER_HRESP_OKAY;
      end
      else
      begin
         phase_reg <= phase_next;
         ready_reg <= ready_next;
         resp_reg  <= resp_next;
      end
   end

   vmot_zero_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE1]
      (rd_go && haddr == MER_OFS_VMOT && !h_read_reg) |=> (hrdata == 32'h0))
      else $error("vertical read without horizontal not zero");
   vmot_pair_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE1]
      (rd_go && haddr == MER_OFS_VMOT && h_read_reg) |=> (hrdata[7:0] == $past(vmot_reg)))
      else $error("vertical read after horizontal wrong");
   exp_freeze_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE5]
      (rd_go && haddr == MER_OFS_EXP_HI) |=> (lo_frz_reg == $past(exposure_count[7:0])))
      else $error("low exposure byte not frozen");
   exp_high_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
      (rd_go && haddr == MER_OFS_EXP_HI) |=> (hrdata[7:0] == $past(exposure_count[15:8])))
      else $error("exposure high byte wrong");
   hmot_load_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6]
      motion_load |=> (hmot_reg == $past(motion_horiz)))
      else $error("horizontal motion not mirrored");
   vmot_load_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6]
      motion_load |=> (vmot_reg == $past(motion_vert)))
      else $error("vertical motion not mirrored");
   surface_quality_byte_load_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6]
      motion_load |=> (surface_quality_byte_reg == $past(surface_quality)))
      else $error("surface quality not mirrored");
   lo_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE5]
      !(rd_go && rd_sel == MER_SEL_EXPHI) |=> $stable(lo_frz_reg))
      else $error("frozen low exposure byte moved");
   write_drop_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6]
      (wr_go && !motion_load) |=> ($stable(hmot_reg) && $stable(vmot_reg) && $stable(surface_quality_byte_reg)))
      else $error("write changed a read-only register");
   idle_zero_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE1]
      (phase_reg == MER_ADDR) |-> (hrdata == 32'h0000_0000))
      else $error("read data outside a data phase");
   byte_only_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
      (hrdata[31:8] == 24'h00_0000))
      else $error("read data wider than a byte");
   bus_okay_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6]
      (hreadyout && hresp == MER_HRESP_OKAY))
      else $error("bus not ready or not okay");
endmodule
`default_nettype wire

// ===== inc/mer_pkg.sv
// constants and types for the motion and exposure test register slice
// Contract
// RULE1: read horizontal before vertical, else vertical zero
// RULE2: exposure is sixteen bits over two bytes
// RULE3: exposure counts shutter-open cycles of last image
// RULE4: counter ticks on the main sensor clock
// RULE5: upper read freezes the matching lower byte
// RULE6: motion bytes mirror last signed link values
`default_nettype none
package mer_pkg;
   // register indices; a register's byte address is four times its index
   localparam logic [11:0] MER_IDX_HMOT   = 12'h003;
   localparam logic [11:0] MER_IDX_VMOT   = 12'h004;
   localparam logic [11:0] MER_IDX_SURFACE_QUALITY_BYTE  = 12'h005;
   localparam logic [11:0] MER_IDX_EXP_HI = 12'h006;
   localparam logic [11:0] MER_IDX_EXP_LO = 12'h007;
   localparam logic [11:0] MER_OFS_HMOT   = {MER_IDX_HMOT[9:0], 2'b00};
   localparam logic [11:0] MER_OFS_VMOT   = {MER_IDX_VMOT[9:0], 2'b00};
   localparam logic [11:0] MER_OFS_SURFACE_QUALITY_BYTE  = {MER_IDX_SURFACE_QUALITY_BYTE[9:0], 2'b00};
   localparam logic [11:0] MER_OFS_EXP_HI = {MER_IDX_EXP_HI[9:0], 2'b00};
   localparam logic [11:0] MER_OFS_EXP_LO = {MER_IDX_EXP_LO[9:0], 2'b00};
   localparam logic [7:0]  MER_RST_HMOT   = 8'h00;
   localparam logic [7:0]  MER_RST_VMOT   = 8'h00;
   localparam logic [7:0]  MER_RST_SURFACE_QUALITY_BYTE  = 8'h00;
   localparam logic [15:0] MER_RST_EXP    = 16'h0164;
   localparam logic [1:0]  MER_HTRANS_NONSEQ = 2'b10;
   localparam logic [1:0]  MER_HTRANS_IDLE   = 2'h0;
   localparam logic        MER_HRESP_OKAY    = 1'h0;
   localparam int          MER_CLK_MHZ    = 100;
   typedef enum logic [0:0] {MER_ADDR = 1'b0, MER_DATA = 1'b1} mer_phase_e;
endpackage
`default_nettype wire

// ===== hw/mer_exp_counter.sv
// counter of shutter-open cycles per image
`timescale 1ns/100ps
`default_nettype none
module mer_exp_counter
   import mer_pkg::*;
#(
   parameter int unsigned COUNT_WIDTH = 16
)
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        shutter_open,
   output logic [COUNT_WIDTH-1:0] exposure_count
);
   logic [COUNT_WIDTH-1:0] run_reg;
   logic [COUNT_WIDTH-1:0] run_next;
   logic [COUNT_WIDTH-1:0] cnt_reg;
   logic [COUNT_WIDTH-1:0] cnt_next;
   logic                   open_d_reg;

   // the reset value must fit, and the count must not exceed one word
   generate
      if (COUNT_WIDTH < 9 || COUNT_WIDTH > 32)
      begin
         $error("exposure counter width out of range");
      end
   endgenerate

   always_comb
   begin
      run_next = run_reg;
      cnt_next = cnt_reg;
      if (shutter_open)
      begin
         // counts every rising main clock edge while open, saturating [RULE4]
         run_next = (run_reg == {COUNT_WIDTH{1'b1}}) ? run_reg : COUNT_WIDTH'(run_reg + 1'b1);
      end
      else if (open_d_reg)
      begin
         // image done: publish and restart [RULE3]
         cnt_next = run_reg;
         run_next = '0;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         run_reg    <= '0;
         cnt_reg    <= COUNT_WIDTH'(MER_RST_EXP);
         open_d_reg <= 1'b0;
      end
      else
      begin
         run_reg    <= run_next;
         cnt_reg    <= cnt_next;
         open_d_reg <= shutter_open;
      end
   end

   assign exposure_count = cnt_reg;

   exp_publish_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE3]
      (open_d_reg && !shutter_open) |=> (cnt_reg == $past(run_reg)))
      else $error("exposure not published at shutter close");
endmodule
`default_nettype wire

// ===== sim/test_motion_exposure_test_regs.sv
// self-checking bench for the motion and exposure test register slice
`timescale 1ns/100ps
`default_nettype none
module test_motion_exposure_test_regs import mer_pkg::*; ;
   logic        clock, rst_n, hsel, hwrite, motion_load, shutter_open;
   logic        hreadyout, hresp;
   wire logic   hready;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata;
   logic [7:0]  motion_horiz, motion_vert, surface_quality;
   int          err_count, samples_checked;
   // rows: write flag, byte address, expected read byte
   logic [20:0] rows [8] = '{{1'b1, MER_OFS_HMOT, 8'h00}, {1'b0, MER_OFS_HMOT, 8'h85},
      {1'b0, MER_OFS_VMOT, 8'h7f}, {1'b0, MER_OFS_VMOT, 8'h00}, {1'b0, MER_OFS_SURFACE_QUALITY_BYTE, 8'h33},
      {1'b0, 12'h020, 8'h00}, {1'b0, MER_OFS_HMOT, 8'h85}, {1'b0, MER_OFS_VMOT, 8'h7f}};
   assign hready = hreadyout;
   mer_regs dut_u (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .motion_load(motion_load), .motion_horiz(motion_horiz),
      .motion_vert(motion_vert), .surface_quality(surface_quality), .shutter_open(shutter_open));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      if (err_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // waits for hready high at a rising edge, bounded
   task automatic wait_ready;
      int n;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1)
      begin
         err_count++;
         complete_run;
      end
   endtask
   // one single word transfer; entered just after a rising edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] e);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= MER_HTRANS_NONSEQ;
      hwrite <= w;
      wait_ready;
      htrans <= MER_HTRANS_IDLE;
      hwdata <= 32'hffff_ffff;
      wait_ready;
      check({31'h0000_0000, hresp}, {31'h0000_0000, MER_HRESP_OKAY});
      if (!w)
         check(hrdata, {24'h00_0000, e});
   endtask
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial
   begin
      {err_count, samples_checked, rst_n, hsel, hwrite, motion_load, shutter_open} = '0;
      {haddr, htrans, hwdata, motion_horiz, motion_vert, surface_quality} = '0;
      hsize = 3'b010;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      motion_load <= 1'b1;
      motion_horiz <= 8'h85;
      motion_vert <= 8'h7f;
      surface_quality <= 8'h33;
      @(posedge clock);
      motion_load <= 1'b0;
      @(posedge clock);
      foreach (rows[i])
         xfer(rows[i][20], rows[i][19:8], rows[i][7:0]);
      // second reset in mid-run, then reset values
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      xfer(1'b0, MER_OFS_HMOT, 8'h00);
      xfer(1'b0, MER_OFS_VMOT, 8'h00);
      xfer(1'b0, MER_OFS_SURFACE_QUALITY_BYTE, 8'h00);
      xfer(1'b0, MER_OFS_EXP_HI, 8'h01);
      xfer(1'b0, MER_OFS_EXP_LO, 8'h64);
      shutter_open <= 1'b1;
      repeat (300) @(posedge clock);
      shutter_open <= 1'b0;
      repeat (3) @(posedge clock);
      xfer(1'b0, MER_OFS_EXP_HI, 8'h01);
      // a new image lands between the two reads; low byte must stay frozen
      shutter_open <= 1'b1;
      repeat (5) @(posedge clock);
      shutter_open <= 1'b0;
      repeat (3) @(posedge clock);
      xfer(1'b0, MER_OFS_EXP_LO, 8'h2c);
      xfer(1'b0, MER_OFS_EXP_HI, 8'h00);
      xfer(1'b0, MER_OFS_EXP_LO, 8'h05);
      // an exposure longer than the counter can hold saturates
      shutter_open <= 1'b1;
      repeat (65540) @(posedge clock);
      shutter_open <= 1'b0;
      repeat (3) @(posedge clock);
      xfer(1'b0, MER_OFS_EXP_HI, 8'hff);
      xfer(1'b0, MER_OFS_EXP_LO, 8'hff);
      complete_run;
   end
endmodule
`default_nettype wire
